/* File: core/sspi_pkg.sv */
// shared constants and types for the signal strength pwm indicator
package sspi_pkg;
  // clock rate and pwm timing
  localparam int CLK_HZ = 40000000;
  localparam int PWM_PERIOD_NS = 64000;
  localparam int PWM_STEPS = 445;
  localparam int PWM_STEP_NS = 144;
  // cycles per period, rounded down so a period never exceeds 64 us
  localparam int PERIOD_CYCLES = PWM_PERIOD_NS / 25;
  // hold timing
  localparam int HOLD_UNIT_MS = 100;
  localparam int HOLD_UNIT_CYCLES = (CLK_HZ / 1000) * HOLD_UNIT_MS;
  localparam logic [7:0] HOLD_RESET = 8'h28;
  localparam logic [7:0] HOLD_FOREVER = 8'hFF;
  localparam logic [7:0] HOLD_OFF = 8'h00;
  // output function selector codes
  localparam logic [1:0] FUNC_DISABLED = 2'h0;
  localparam logic [1:0] FUNC_STRENGTH = 2'h1;
  localparam logic [1:0] FUNC_RESET = 2'h1;
  // margin to duty mapping: duty steps = base + margin * slope / 10
  // 0 dB gives 24 %, each dB about 1.7 % of period
  localparam logic [8:0] DUTY_BASE_STEPS = 9'h06B;
  localparam logic [8:0] DUTY_MIN_STEPS = 9'h005;
  localparam logic [8:0] DUTY_MAX_STEPS = 9'h1BD;
  localparam int DUTY_SLOPE_X10 = 76;
  // received packet report
  typedef struct packed {
    logic valid;
    logic signed [7:0] margin_db;
  } sspi_packet_type;
endpackage

/* File: core/sspi_duty_map.sv */
// maps a strength margin in dB to a duty in pwm steps
`timescale 1ns/1ps
module sspi_duty_map (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // margin in, registered duty out
  input wire logic signed [7:0] margin_db,
  output logic [8:0] duty_steps
);
  import sspi_pkg::*;

  logic signed [15:0] scaled;
  logic signed [15:0] sum;
  logic [8:0] next_duty;

  // linear fit through 41/58/75 % at 10/20/30 dB
  assign scaled = (16'(margin_db) * 16'(DUTY_SLOPE_X10)) / 16'sd10;
  assign sum = $signed(16'(DUTY_BASE_STEPS)) + scaled;
  // below sensitivity still shows at least 1 %, never zero
  // bounds kept signed: an unsigned side would make a negative sum huge
  assign next_duty = (sum < $signed(16'(DUTY_MIN_STEPS))) ? DUTY_MIN_STEPS :
                     (sum > $signed(16'(DUTY_MAX_STEPS))) ? DUTY_MAX_STEPS :
                     sum[8:0];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      duty_steps <= 9'h000;
    end else begin
      duty_steps <= next_duty;
    end
  end
endmodule

/* File: core/sspi_top.sv */
// signal strength pwm indicator: hold timer and pwm output stage
// Notes on behaviour
// - period is 64 us split into 445 steps of about 144 ns.
// - at or below sensitivity use 1 to 24 percent, stronger up to 100.
// - zero duty, a constant low, means indicator inactive, or from the first packet to the period end.
// - 10, 20, 30 dB margin give 41, 58, 75 percent high time.
// - hold setting 1 to 0xFE keeps last packet duty for setting times 100 ms.
// - on hold expiry output goes low until another packet arrives or hold is set to 0xFF.
// - after reset output stays low until the first packet is received.
// - hold setting 0xFF never times out, always shows last packet.
// - hold setting spans 0 to 0xFF, resets to 0x28, four seconds.
// - waveform reaches the pulse pin only when function select is 1.
`timescale 1ns/1ps
module sspi_top #(
  parameter int HOLD_UNIT = sspi_pkg::HOLD_UNIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // radio receive path report, one-cycle valid per good packet
  input sspi_pkg::sspi_packet_type rx_packet,
  // configuration, from same-clock logic
  input wire logic [7:0] strength_indicator_hold_time,
  input wire logic [1:0] first_output_function_select,
  // indicator pin and state
  output logic first_pulse_output,
  output logic indicator_active
);
  import sspi_pkg::*;

  // strength path
  logic [8:0] mapped_duty;
  logic [8:0] pending_duty;
  logic [8:0] live_duty;
  logic pending_new;
  logic next_pending_new;
  logic latch_now;
  logic load_live;
  logic [8:0] next_live_duty;
  // period and step timing
  logic [11:0] period_cnt;
  logic [11:0] next_period_cnt;
  logic [11:0] sub_cnt;
  logic [11:0] next_sub_cnt;
  logic [8:0] step_cnt;
  logic [8:0] next_step_cnt;
  logic period_end;
  logic step_tick;
  logic step_last;
  // hold timing
  logic [31:0] unit_cnt;
  logic [31:0] next_unit_cnt;
  logic [7:0] units_left;
  logic [7:0] next_units_left;
  logic unit_tick;
  logic unit_dec;
  logic pkt_seen;
  logic hold_disabled;
  logic hold_forever;
  logic expired;
  // output stage
  logic live_on;
  logic func_on;
  logic below_duty;
  logic next_out;

  // registered mapper, so its duty trails the packet strobe by a cycle
  sspi_duty_map u_map (
    .clk(clk),
    .resetn(resetn),
    .margin_db(rx_packet.margin_db),
    .duty_steps(mapped_duty)
  );

  // strobe delayed to line up with the mapper output
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_now <= 1'b0;
    end else begin
      latch_now <= rx_packet.valid;
    end
  end

  // period counter: 2560 cycles of 25 ns is 64 us
  assign period_end = (period_cnt == 12'(PERIOD_CYCLES - 1));
  assign next_period_cnt = period_end ? 12'h000 : period_cnt + 12'h001;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      period_cnt <= 12'h000;
    end else begin
      period_cnt <= next_period_cnt;
    end
  end

  // step accumulator: adds 445 a cycle modulo 2560, one tick per wrap,
  // so exactly 445 steps fit each period; a 144 ns step is no whole
  // number of 25 ns cycles, so steps come out 5 or 6 cycles long
  assign step_tick = (sub_cnt >= 12'(PERIOD_CYCLES - PWM_STEPS));
  assign next_sub_cnt = period_end ? 12'h000 :
                        step_tick ? sub_cnt - 12'(PERIOD_CYCLES - PWM_STEPS) :
                        sub_cnt + 12'(PWM_STEPS);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sub_cnt <= 12'h000;
    end else begin
      sub_cnt <= next_sub_cnt;
    end
  end

  // step index saturates on the last step; the period wrap restarts it
  assign step_last = (step_cnt == 9'(PWM_STEPS - 1));
  assign next_step_cnt = period_end ? 9'h000 :
                         (step_tick && !step_last) ? step_cnt + 9'h001 :
                         step_cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      step_cnt <= 9'h000;
    end else begin
      step_cnt <= next_step_cnt;
    end
  end

  // new strength waits for the period boundary to avoid runt pulses;
  // a strobe on the boundary cycle itself goes live at once
  assign load_live = period_end && (pending_new || latch_now);
  assign next_live_duty = latch_now ? mapped_duty : pending_duty;
  assign next_pending_new = latch_now ? 1'b1 :
                            period_end ? 1'b0 : pending_new;
  // strength of each good packet, held until the boundary
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pending_duty <= 9'h000;
    end else if (latch_now) begin
      pending_duty <= mapped_duty;
    end
  end

  // pending flag, a new strobe wins over the boundary clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pending_new <= 1'b0;
    end else begin
      pending_new <= next_pending_new;
    end
  end

  // duty shown by the pin, changes only at a period start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      live_duty <= 9'h000;
    end else if (load_live) begin
      live_duty <= next_live_duty;
    end
  end

  // hold setting decode; 0 and 0xFF act at once, other values only
  // take effect when the next packet reloads the unit count
  assign hold_disabled = (strength_indicator_hold_time == HOLD_OFF);
  assign hold_forever = (strength_indicator_hold_time == HOLD_FOREVER);
  assign unit_tick = (unit_cnt == 32'(HOLD_UNIT - 1));
  assign unit_dec = unit_tick && (units_left != 8'h00) && !hold_forever;
  assign expired = (units_left == 8'h00) && !hold_forever;

  // unit counter restarts on each packet, so a hold is never cut short
  assign next_unit_cnt = (latch_now || unit_tick) ? 32'h00000000 :
                         unit_cnt + 32'h00000001;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      unit_cnt <= 32'h00000000;
    end else begin
      unit_cnt <= next_unit_cnt;
    end
  end

  // whole 8-bit range loads as is; 0x28 comes from the config source
  assign next_units_left = latch_now ? strength_indicator_hold_time :
                           unit_dec ? units_left - 8'h01 :
                           units_left;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      units_left <= 8'h00;
    end else begin
      units_left <= next_units_left;
    end
  end

  // first packet seen since reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pkt_seen <= 1'b0;
    end else if (latch_now) begin
      pkt_seen <= 1'b1;
    end
  end

  // active only after a packet and with a live hold, for any function select;
  // a packet after expiry shows the old duty until the period ends,
  // traded for never cutting a period short
  assign live_on = pkt_seen && !hold_disabled && !expired;
  assign func_on = (first_output_function_select == FUNC_STRENGTH);
  assign below_duty = (step_cnt < live_duty);
  assign next_out = live_on && func_on && below_duty;

  // pulse pin, registered so it never glitches
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_pulse_output <= 1'b0;
    end else begin
      first_pulse_output <= next_out;
    end
  end

  // indicator state, registered alongside the pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      indicator_active <= 1'b0;
    end else begin
      indicator_active <= live_on;
    end
  end
endmodule

/* File: verification/sspi_meter.sv */
// indicator meter model: high-time tally of the pulse pin
`timescale 1ns/1ps
module sspi_meter (
  // clock and control
  input wire logic clk,
  input wire logic clear,
  // indicator pin in, tally out
  input wire logic pin,
  output logic [15:0] high_cycles
);
  // an rc filter seen as a plain count, no decay between reads
  always_ff @(posedge clk) begin
    high_cycles <= clear ? 16'h0 : high_cycles + 16'(pin);
  end
endmodule

/* File: verification/sspi_assertions.sv */
// concurrent checks on the indicator ports
`timescale 1ns/1ps
module sspi_checker import sspi_pkg::*; #(parameter int HOLD_UNIT = 20) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // watched ports
  input sspi_pkg::sspi_packet_type rx_packet,
  input wire logic [7:0] strength_indicator_hold_time,
  input wire logic [1:0] first_output_function_select,
  input wire logic first_pulse_output,
  input wire logic indicator_active
);
  wire [7:0] h = strength_indicator_hold_time;
  wire a = indicator_active;
  wire p = first_pulse_output;
  wire v = rx_packet.valid;
  wire sel_on = (first_output_function_select == FUNC_STRENGTH);
  logic seen;
  logic [31:0] t;
  // packet seen flag, cycles since last packet
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) {seen, t} <= 33'h0;
    else {seen, t} <= {seen | v, v ? 32'h0 : t + 32'h1};
  // one unit of slack, though the unit counter restarts on each packet
  wire [31:0] lim = (32'(h) + 32'h1) * HOLD_UNIT + 32'h8;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_pkt; v && h != HOLD_OFF; endsequence
  sequence s_calm; $stable(h)[*4] ##0 a && h != HOLD_FOREVER; endsequence
  // rise at a period start, with indicator and routing already on
  sequence s_rise; $rose(p) && $past(a) && $past(sel_on, 2); endsequence
  a_sel_gate: assert property (
    (first_output_function_select != 2'h1)[*3] |-> !p) else $error("ungated");
  a_idle_low: assert property ((!a)[*3] |-> !p) else $error("idle");
  a_pkt_live: assert property (s_pkt |-> ##3 a)
    else $error("late");
  a_off_quiet: assert property ((h == 8'h0)[*3] |-> !a)
    else $error("on");
  a_boot_low: assert property (!seen |-> !a) else $error("early");
  a_hold_ever: assert property (
    a && h == HOLD_FOREVER ##1 h == HOLD_FOREVER |-> a) else $error("lapsed");
  a_hold_end: assert property (s_calm |-> t <= lim)
    else $error("stuck");
  // a pulse lasts a step unless the indicator or routing drops meanwhile
  a_min_step: assert property (
    s_rise |=> (p || !a || !$past(sel_on))[*4]) else $error("thin");
endmodule
bind sspi_top sspi_checker #(.HOLD_UNIT(HOLD_UNIT)) i_chk (.clk(clk),
  .resetn(resetn), .rx_packet(rx_packet),
  .strength_indicator_hold_time(strength_indicator_hold_time),
  .first_output_function_select(first_output_function_select),
  .first_pulse_output(first_pulse_output),
  .indicator_active(indicator_active));

/* File: verification/tb_top.sv */
// indicator testbench
`timescale 1ns/1ps
module tb_top;
  import sspi_pkg::*;
  logic clk = 1'h0, resetn = 1'h0, clr = 1'h1, pin, act;
  sspi_packet_type pkt = '0;
  logic [7:0] hold = HOLD_RESET;
  logic [1:0] sel = FUNC_STRENGTH;
  logic [15:0] hc;
  int failures = 0, compares = 0;
  always #12.5 clk = ~clk;
  sspi_top #(.HOLD_UNIT(1000)) i_dut (.clk(clk), .resetn(resetn),
    .rx_packet(pkt), .strength_indicator_hold_time(hold),
    .first_output_function_select(sel), .first_pulse_output(pin),
    .indicator_active(act));
  sspi_meter i_m (.clk(clk), .clear(clr), .pin(pin), .high_cycles(hc));
  task check(string n, logic [15:0] s, logic [15:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s exp %0h seen %0h", n, e, s);
    end
  endtask
  task cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  // new duty shows only from the next period start
  task send(logic [7:0] m);
    pkt = '{1'h1, m};
    cyc(1);
    pkt = '0;
    cyc(2600);
  endtask
  // rounded high percent over one full period
  task duty(int e);
    clr = 1'h0;
    cyc(PERIOD_CYCLES);
    check("duty", 16'((hc * 100 + 1280) / PERIOD_CYCLES), 16'(e));
    clr = 1'h1;
  endtask
  task t_map;
    // table points, sensitivity, weakest and strongest margins
    int m[6] = '{10, 20, 30, 0, -128, 127};
    int e[6] = '{41, 58, 75, 24, 1, 100};
    foreach (m[i]) begin
      send(8'(m[i]));
      duty(e[i]);
    end
  endtask
  task t_expiry;
    hold = 8'h04;
    send(8'h0A);
    check("act", act, 1'h1);
    cyc(2500);
    check("act", act, 1'h0);
    duty(0);
  endtask
  task t_sel;
    for (int s = 0; s < 4; s++) begin
      sel = 2'(s);
      cyc(3);
      duty(s == 1 ? 41 : 0);
    end
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    cyc(6);
    resetn = 1'h1;
    duty(0);
    t_map;
    hold = 8'h00;
    send(8'h1E);
    check("act", act, 1'h0);
    duty(0);
    t_expiry;
    // 0xFF set mid-hold must stop a 4-unit count before it runs out
    send(8'h1E);
    hold = HOLD_FOREVER;
    cyc(6000);
    check("act", act, 1'h1);
    duty(75);
    send(8'h0A);
    t_sel;
    wrap_up;
  end
endmodule
